// ===== opamp_ctrl_pkg.sv
// Package with register offsets, field positions, reset values and codes for the amplifier control.
package opamp_ctrl_pkg;
  localparam logic [11:0] ctrl0_offset    = 12'h000;
  localparam logic [11:0] ctrl1_offset    = 12'h004;
  localparam logic [11:0] ctrl2_offset    = 12'h008;
  localparam logic [11:0] override_offset = 12'h00c;
  localparam logic [11:0] trim_offset     = 12'h010;
  localparam logic [11:0] status_offset   = 12'h014;
  localparam logic [11:0] adc_link_offset = 12'h018;
  localparam int enable_bit     = 7;
  localparam int unity_bit      = 3;
  localparam int soc_lsb        = 0;
  localparam int gain_lsb       = 4;
  localparam int ladder_bit     = 3;
  localparam int neg_pin_lsb    = 0;
  localparam int neg_chan_lsb   = 4;
  localparam int pos_chan_lsb   = 0;
  localparam int pos_pin_lsb    = 8;
  localparam int or_enable_bit  = 7;
  localparam int or_pol_bit     = 6;
  localparam int or_src_lsb     = 8;
  localparam int or_high_lsb    = 0;
  localparam int or_low_lsb     = 3;
  localparam int adc_link_bit   = 0;
  localparam int adc_chan_lsb   = 8;
  localparam logic [7:0] trim_factory_default = 8'h80;
  localparam logic [2:0] chan_ladder  = 3'h1;
  localparam logic [2:0] chan_pin     = 3'h2;
  localparam logic [1:0] soc_basic    = 2'h0;
  localparam logic [1:0] soc_to_gnd   = 2'h1;
  localparam logic [1:0] soc_to_vdd   = 2'h2;
  // Override mode field codes: basic, unity gain, rail high, rail low.
  localparam logic [2:0] hw_basic     = 3'h0;
  localparam logic [2:0] hw_unity     = 3'h1;
  localparam logic [2:0] hw_rail_high = 3'h2;
  localparam logic [2:0] hw_rail_low  = 3'h3;
  typedef enum logic [1:0] {mode_basic, mode_unity, mode_rail_high, mode_rail_low} amp_mode_type;
endpackage : opamp_ctrl_pkg

// ===== opamp_mode_override_control.sv
// APB-controlled mode, override, source and trim control for the on-chip amplifier.
`timescale 1ns/100ps
module opamp_mode_override_control
  import opamp_ctrl_pkg::*;
#(
  parameter int src_count = 4
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [src_count-1:0] override_sources,
  input  wire logic [7:0]           factory_trim,
  output logic                      amp_active,
  output logic                      amp_output_pin_port_oe_n,
  output amp_mode_type              amp_mode,
  output logic                      fb_to_inv_input,
  output logic                      amp_inv_pin_free,
  output logic [2:0]                pos_source,
  output logic [2:0]                neg_source,
  output logic                      pos_pin_connect,
  output logic                      neg_pin_connect,
  output logic [2:0]                amp_noninv_pin,
  output logic [2:0]                amp_inv_pin,
  output logic                      ladder_active,
  output logic [2:0]                ladder_tap,
  output logic [7:0]                offset_trim,
  output logic                      adc_from_amp
);

  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [10:0] ctrl2_ff;
  logic [9:0]  override_config_reg_ff;
  logic [7:0]  offset_trim_reg_ff;
  logic        trim_load_ff;
  // Wide enough for the link bit and the whole three-bit ADC channel field.
  logic [10:0] adc_link_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  wire logic       amp_enable              = ctrl0_ff[enable_bit];
  wire logic       unity_gain_sel          = ctrl0_ff[unity_bit];
  wire logic [1:0] soc_field               = ctrl0_ff[soc_lsb +: 2];
  wire logic [2:0] gain_tap_sel            = ctrl1_ff[gain_lsb +: 3];
  wire logic       ladder_enable           = ctrl1_ff[ladder_bit];
  wire logic [2:0] neg_pin_sel             = ctrl1_ff[neg_pin_lsb +: 3];
  wire logic [2:0] neg_channel_sel         = ctrl2_ff[neg_chan_lsb +: 3];
  wire logic [2:0] pos_channel_sel         = ctrl2_ff[pos_chan_lsb +: 3];
  wire logic [2:0] pos_pin_sel             = ctrl2_ff[pos_pin_lsb +: 3];
  wire logic       override_enable         = override_config_reg_ff[or_enable_bit];
  wire logic       override_polarity       = override_config_reg_ff[or_pol_bit];
  wire logic [1:0] override_source_sel     = override_config_reg_ff[or_src_lsb +: 2];
  wire logic [2:0] override_mode_when_high = override_config_reg_ff[or_high_lsb +: 3];
  wire logic [2:0] override_mode_when_low  = override_config_reg_ff[or_low_lsb +: 3];
  wire logic       adc_link                = adc_link_ff[adc_link_bit];
  wire logic [2:0] adc_pos_channel_sel     = adc_link_ff[adc_chan_lsb +: 3];

  wire logic access_phase = psel & penable;
  wire logic wr_en        = access_phase & pwrite;
  wire logic addr_ok      = (paddr == ctrl0_offset) | (paddr == ctrl1_offset) |
                            (paddr == ctrl2_offset) | (paddr == override_offset) |
                            (paddr == trim_offset) | (paddr == status_offset) |
                            (paddr == adc_link_offset);

  // Every source is synchronised so switching the selector never samples a raw pin.
  logic [src_count-1:0] srcs_sync1_ff;
  logic [src_count-1:0] srcs_sync2_ff;
  wire logic src_raw_sel = srcs_sync2_ff[override_source_sel];
  wire logic src_level   = src_raw_sel ^ override_polarity;

  function automatic amp_mode_type decode_hw(input logic [2:0] code);
    case (code)
      hw_unity:     decode_hw = mode_unity;
      hw_rail_high: decode_hw = mode_rail_high;
      hw_rail_low:  decode_hw = mode_rail_low;
      default:      decode_hw = mode_basic;
    endcase
  endfunction : decode_hw

  function automatic amp_mode_type decode_soc(input logic [1:0] code, input logic ug);
    case (code)
      soc_to_vdd: decode_soc = mode_rail_high;
      soc_to_gnd: decode_soc = mode_rail_low;
      soc_basic:  decode_soc = ug ? mode_unity : mode_basic;
      default:    decode_soc = mode_basic;
    endcase
  endfunction : decode_soc

  // Override mode selection by source level after polarity.
  wire amp_mode_type hw_mode = src_level ? decode_hw(override_mode_when_high)
                                         : decode_hw(override_mode_when_low);
  wire amp_mode_type sel_mode = override_enable ? hw_mode
                                                : decode_soc(soc_field, unity_gain_sel);
  wire amp_mode_type nxt_mode = amp_enable ? sel_mode : mode_basic;

  wire logic nxt_pos_pin = amp_enable & (pos_channel_sel == chan_pin);
  wire logic nxt_neg_pin = amp_enable & (neg_channel_sel == chan_pin) &
                           (nxt_mode != mode_unity);
  wire logic nxt_unity   = amp_enable & (nxt_mode == mode_unity);
  // ADC channel choice wins over the positive pin field when linked; the inverting pin always follows its own field.
  wire logic [2:0] nxt_noninv = adc_link ? adc_pos_channel_sel : pos_pin_sel;
  wire logic [2:0] nxt_inv    = neg_pin_sel;
  wire logic [2:0] nxt_pos_src = (pos_channel_sel > 3'h5) ? 3'h0 : pos_channel_sel;
  wire logic [2:0] nxt_neg_src = ((neg_channel_sel > 3'h5) || (neg_channel_sel == 3'h3))
                                 ? 3'h0 : neg_channel_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srcs_sync1_ff <= '0;
      srcs_sync2_ff <= '0;
    end else begin
      srcs_sync1_ff <= override_sources;
      srcs_sync2_ff <= srcs_sync1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff               <= '0;
      ctrl1_ff               <= '0;
      ctrl2_ff               <= '0;
      override_config_reg_ff <= '0;
      adc_link_ff            <= '0;
    end else if (wr_en) begin
      if (paddr == ctrl0_offset) ctrl0_ff <= pwdata[7:0] & 8'hab;
      if (paddr == ctrl1_offset) ctrl1_ff <= pwdata[7:0] & 8'h7f;
      if (paddr == ctrl2_offset) ctrl2_ff <= pwdata[10:0];
      if (paddr == override_offset) override_config_reg_ff <= pwdata[9:0];
      if (paddr == adc_link_offset) adc_link_ff <= pwdata[10:0] & 11'h701;
    end
  end

  // The factory value is a port, so it is loaded by a clocked step after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_trim_reg_ff <= trim_factory_default;
      trim_load_ff       <= 1'b1;
    end else if (trim_load_ff) begin
      offset_trim_reg_ff <= factory_trim;
      trim_load_ff       <= 1'b0;
    end else if (wr_en && (paddr == trim_offset)) begin
      offset_trim_reg_ff <= pwdata[7:0];
    end
  end

  wire logic [31:0] status_word = {24'h0, ladder_active, adc_from_amp, src_level,
                                   amp_active, 2'h0, amp_mode};
  wire logic [31:0] rd_word =
      (paddr == ctrl0_offset)    ? {24'h0, ctrl0_ff} :
      (paddr == ctrl1_offset)    ? {24'h0, ctrl1_ff} :
      (paddr == ctrl2_offset)    ? {21'h0, ctrl2_ff} :
      (paddr == override_offset) ? {22'h0, override_config_reg_ff} :
      (paddr == trim_offset)     ? {24'h0, offset_trim_reg_ff} :
      (paddr == status_offset)   ? status_word :
      (paddr == adc_link_offset) ? {21'h0, adc_link_ff} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= (psel & ~penable & ~pwrite) ? rd_word : prdata_ff;
      pslverr_ff <= psel & ~penable & ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_active               <= 1'b0;
      amp_output_pin_port_oe_n <= 1'b0;
      amp_mode                 <= mode_basic;
      fb_to_inv_input          <= 1'b0;
      amp_inv_pin_free         <= 1'b0;
      pos_source               <= '0;
      neg_source               <= '0;
      pos_pin_connect          <= 1'b0;
      neg_pin_connect          <= 1'b0;
      amp_noninv_pin           <= '0;
      amp_inv_pin              <= '0;
      ladder_active            <= 1'b0;
      ladder_tap               <= '0;
      adc_from_amp             <= 1'b0;
    end else begin
      amp_active               <= amp_enable;
      amp_output_pin_port_oe_n <= amp_enable;
      amp_mode                 <= nxt_mode;
      fb_to_inv_input          <= nxt_unity;
      amp_inv_pin_free         <= nxt_unity;
      pos_source               <= nxt_pos_src;
      neg_source               <= nxt_neg_src;
      pos_pin_connect          <= nxt_pos_pin;
      neg_pin_connect          <= nxt_neg_pin;
      amp_noninv_pin           <= nxt_noninv;
      amp_inv_pin              <= nxt_inv;
      ladder_active            <= amp_enable & ladder_enable &
                                  ((pos_channel_sel == chan_ladder) |
                                   (neg_channel_sel == chan_ladder));
      ladder_tap               <= gain_tap_sel;
      adc_from_amp             <= amp_enable & adc_link;
    end
  end

  assign offset_trim = offset_trim_reg_ff;
  assign prdata      = prdata_ff;
  assign pslverr     = pslverr_ff & access_phase;
  // Read data is captured in setup, so every access completes in its first access cycle.
  assign pready      = 1'b1;

endmodule : opamp_mode_override_control

// ===== opamp_mode_override_control_sva.sv
// Port assertions for the amplifier control block.
`timescale 1ns/100ps
module opamp_mode_override_control_sva
  import opamp_ctrl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        amp_active,
  input wire logic        amp_output_pin_port_oe_n,
  input amp_mode_type     amp_mode,
  input wire logic        fb_to_inv_input,
  input wire logic        amp_inv_pin_free,
  input wire logic [7:0]  offset_trim,
  input wire logic [7:0]  factory_trim,
  input wire logic        adc_from_amp,
  input wire logic [2:0]  ladder_tap
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_wr = psel && penable && pwrite;
  property p_port_off; amp_output_pin_port_oe_n == amp_active; endproperty
  a_port_off: assert property (p_port_off)
    else $error("port driver state does not follow enable");
  property p_off_basic; !amp_active |-> amp_mode == mode_basic; endproperty
  a_off_basic: assert property (p_off_basic)
    else $error("mode not basic while disabled");
  property p_unity_fb; (fb_to_inv_input && amp_inv_pin_free) == (amp_active && amp_mode == mode_unity); endproperty
  a_unity_fb: assert property (p_unity_fb)
    else $error("unity feedback does not match mode");
  property p_adc_amp; adc_from_amp |-> amp_active; endproperty
  a_adc_amp: assert property (p_adc_amp)
    else $error("adc route without enabled amplifier");
  property p_trim_load; $rose(presetn) |-> ##1 offset_trim == factory_trim; endproperty
  a_trim_load: assert property (p_trim_load)
    else $error("trim not reloaded after reset");
  property p_en_wr; acc_wr && paddr == ctrl0_offset |-> ##2 amp_active == $past(pwdata[enable_bit], 2); endproperty
  a_en_wr: assert property (p_en_wr)
    else $error("enable write not applied");
  property p_gain_wr; acc_wr && paddr == ctrl1_offset |-> ##2 ladder_tap == $past(pwdata[gain_lsb +: 3], 2); endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain tap does not follow write");
  property p_link_wr; acc_wr && paddr == adc_link_offset |-> ##2 adc_from_amp == ($past(pwdata[adc_link_bit], 2) && amp_active); endproperty
  a_link_wr: assert property (p_link_wr)
    else $error("adc route does not follow write");
endmodule : opamp_mode_override_control_sva
bind opamp_mode_override_control opamp_mode_override_control_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .amp_active(amp_active), .amp_output_pin_port_oe_n(amp_output_pin_port_oe_n), .amp_mode(amp_mode),
  .fb_to_inv_input(fb_to_inv_input), .amp_inv_pin_free(amp_inv_pin_free), .offset_trim(offset_trim),
  .factory_trim(factory_trim), .adc_from_amp(adc_from_amp), .ladder_tap(ladder_tap));

// ===== amp_far_side_model.sv
// Far-side model: override signal sources and the factory trim level.
`timescale 1ns/100ps
module amp_far_side_model #(
  parameter logic [7:0] factory_value = 8'h5a
) (
  input  wire logic       pclk,
  input  wire logic       src_level,
  output logic      [3:0] override_sources,
  output logic      [7:0] factory_trim
);
  logic [2:0] noise_ff = 3'h5;
  // Unused sources toggle every cycle, so picking the wrong source shows up.
  always @(posedge pclk) noise_ff <= ~noise_ff;
  assign override_sources = {noise_ff, src_level};
  assign factory_trim     = factory_value;
endmodule : amp_far_side_model

// ===== opamp_mode_override_control_bench.sv
// Self-checking bench for the amplifier control block.
`timescale 1ns/100ps
`define check(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module opamp_mode_override_control_bench
  import opamp_ctrl_pkg::*;
;
  localparam logic [7:0] factory_value = 8'h5a;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         src_level = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic [7:0]   offset_trim, factory_trim;
  logic [3:0]   override_sources;
  logic [2:0]   pos_source, neg_source, amp_noninv_pin, amp_inv_pin, ladder_tap;
  logic         pready, pslverr, amp_active, amp_output_pin_port_oe_n, fb_to_inv_input;
  logic         amp_inv_pin_free, pos_pin_connect, neg_pin_connect, ladder_active, adc_from_amp;
  amp_mode_type amp_mode;
  int           fail_count = 0, checked = 0, cycles = 0;
  amp_mode_type soc_exp [4] = '{mode_basic, mode_rail_low, mode_rail_high, mode_basic};
  always #25 pclk = ~pclk;
  amp_far_side_model #(.factory_value(factory_value)) u_far (.pclk, .src_level, .override_sources,
    .factory_trim);
  opamp_mode_override_control #(.src_count(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .override_sources, .factory_trim, .amp_active,
    .amp_output_pin_port_oe_n, .amp_mode, .fb_to_inv_input, .amp_inv_pin_free, .pos_source,
    .neg_source, .pos_pin_connect, .neg_pin_connect, .amp_noninv_pin, .amp_inv_pin,
    .ladder_active, .ladder_tap, .offset_trim, .adc_from_amp);
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  initial begin
    logic [31:0] q;
    logic        e;
    logic [2:0]  hi, lo;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    `check("trim", factory_value, offset_trim)
    apb(1'b0, 12'h01c, 32'h0, q, e);
    `check("unmapped data", 32'h0, q)
    `check("unmapped err", 1'b1, e)
    for (int k = 0; k < 4; k++) begin
      wr(ctrl0_offset, 32'h80 | 32'(k));
      settle(3);
      `check("soc mode", soc_exp[k], amp_mode)
    end
    wr(ctrl0_offset, 32'h88);
    settle(3);
    `check("unity", mode_unity, amp_mode)
    `check("feedback", 1'b1, fb_to_inv_input & amp_inv_pin_free)
    `check("port off", 1'b1, amp_output_pin_port_oe_n)
    wr(ctrl0_offset, 32'h0a);
    settle(3);
    `check("active", 1'b0, amp_active)
    `check("off mode", mode_basic, amp_mode)
    `check("port on", 1'b0, amp_output_pin_port_oe_n)
    wr(ctrl0_offset, 32'h80);
    for (int k = 0; k < 8; k++) begin
      hi = k[2] ? hw_unity : hw_rail_high;
      lo = k[2] ? hw_basic : hw_rail_low;
      wr(override_offset, {24'h0, 1'b1, k[0], lo, hi});
      src_level <= k[1];
      settle(4);
      `check("override", amp_mode_type'((k[1] ^ k[0]) ? hi[1:0] : lo[1:0]), amp_mode)
    end
    wr(override_offset, 32'h0);
    wr(ctrl1_offset, 32'h7b);
    wr(ctrl2_offset, 32'h512);
    settle(3);
    `check("pos src", 3'h2, pos_source)
    `check("pos pin", 4'hd, {pos_pin_connect, amp_noninv_pin})
    `check("neg src", 3'h1, neg_source)
    `check("ladder", 4'hf, {ladder_active, ladder_tap})
    wr(ctrl1_offset, 32'h03);
    wr(ctrl2_offset, 32'h727);
    settle(3);
    `check("reserved src", 3'h0, pos_source)
    `check("neg pin", 4'hb, {neg_pin_connect, amp_inv_pin})
    `check("ladder low", 4'h0, {ladder_active, ladder_tap})
    wr(adc_link_offset, 32'h101);
    settle(3);
    `check("adc pin", 3'h1, amp_noninv_pin)
    `check("adc route", 1'b1, adc_from_amp)
    wr(trim_offset, 32'h3c);
    apb(1'b0, trim_offset, 32'h0, q, e);
    `check("trim read", 8'h3c, q[7:0])
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    `check("trim reload", factory_value, offset_trim)
    wrap_up();
  end
endmodule : opamp_mode_override_control_bench
